// *** src/cip_pkg.sv ***
package cip_pkg;

  localparam int NUM_INT = 8;
  localparam int NUM_EXT = 2;
  localparam int NUM_SRC = NUM_INT + NUM_EXT;
  localparam int PRI_W = 2;

  localparam logic [7:0] IVH_RESET  = 8'h00;
  localparam logic [7:0] EVH_RESET  = 8'h00;
  localparam logic [7:0] PSTK_RESET = 8'h00;

  // fixed low bytes of service-routine addresses
  localparam logic [7:0] INT_LOW_STEP = 8'h10;
  localparam logic [7:0] EXT_LOW_BASE = 8'h00;
  localparam logic [7:0] EXT_LOW_STEP = 8'h08;

  // restart trap vectors that exist
  localparam logic [7:0] RST_V10 = 8'h10;
  localparam logic [7:0] RST_V18 = 8'h18;
  localparam logic [7:0] RST_V20 = 8'h20;
  localparam logic [7:0] RST_V28 = 8'h28;
  localparam logic [7:0] RST_V38 = 8'h38;

  typedef enum logic [3:0] {
    OP_NONE, OP_PRI_SET, OP_PRI_RESTORE, OP_PRI_PUSH, OP_PRI_POP, OP_INT_RETURN,
    OP_RD_INTV, OP_WR_INTV, OP_RD_EXTV, OP_WR_EXTV, OP_RST
  } cip_op_type;

  typedef enum logic [1:0] {MV_SINGLE, MV_REPEAT, MV_WORD} cip_mv_cmd_type;

endpackage

// *** src/cip_arbiter.sv ***
`timescale 1ns/1ps
module cip_arbiter import cip_pkg::*; (
  input  wire logic [NUM_SRC-1:0]       req,
  input  wire logic [2*NUM_SRC-1:0]     lvl,
  input  wire logic [PRI_W-1:0]         cur,
  output logic                          hit,
  output logic [3:0]                    idx,
  output logic [PRI_W-1:0]              sel_lvl
);

  // highest level wins, lowest index breaks ties
  always_comb begin
    hit = 1'b0;
    idx = 4'h0;
    sel_lvl = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && (lvl[2*i+:2] > cur) && (lvl[2*i+:2] >= sel_lvl)) begin
        hit = 1'b1;
        idx = 4'(i);
        sel_lvl = lvl[2*i+:2];
      end
    end
  end

endmodule // cip_arbiter

// *** src/cip_io_mover.sv ***
`timescale 1ns/1ps
module cip_io_mover import cip_pkg::*; (
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           start,
  input  wire cip_mv_cmd_type cmd,
  input  wire logic           down,
  input  wire logic [15:0]    hl_in,
  input  wire logic [15:0]    de_in,
  input  wire logic [15:0]    bc_in,
  input  wire logic [15:0]    word_in,
  input  wire logic [7:0]     mem_rdata,
  input  wire logic           pause,
  output logic                mem_rd,
  output logic [15:0]         mem_addr,
  output logic                io_we,
  output logic [15:0]         io_addr,
  output logic [7:0]          io_wdata,
  output logic [15:0]         hl,
  output logic [15:0]         de,
  output logic [15:0]         bc,
  output logic                busy,
  output logic                iter_pt,
  output logic                done
);

  typedef enum logic [2:0] {MS_IDLE, MS_RD, MS_WR, MS_GAP, MS_WHI} cip_ms_type;

  typedef struct packed {
    cip_ms_type  st;
    logic [15:0] hl;
    logic [15:0] de;
    logic [15:0] bc;
    logic [15:0] word;
    logic        rep;
    logic        down;
    logic        mem_rd;
    logic        io_we;
    logic        iter;
    logic        done;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
  } cip_mv_state_type;

  cip_mv_state_type s;
  cip_mv_state_type next_s;

  always_comb begin
    next_s = s;
    next_s.mem_rd = 1'b0;
    next_s.io_we = 1'b0;
    next_s.iter = 1'b0;
    next_s.done = 1'b0;
    case (s.st)
      MS_IDLE: begin
        if (start) begin
          next_s.hl = hl_in;
          next_s.de = de_in;
          next_s.bc = bc_in;
          next_s.word = word_in;
          next_s.rep = (cmd == MV_REPEAT);
          next_s.down = down;
          if (cmd == MV_WORD) begin
            next_s.io_we = 1'b1;
            next_s.io_addr = de_in;
            next_s.io_wdata = word_in[7:0];
            next_s.st = MS_WHI;
          end else begin
            next_s.mem_rd = 1'b1;
            next_s.st = MS_RD;
          end
        end
      end
      MS_RD: next_s.st = MS_WR;
      MS_WR: begin
        // byte at hl goes to io space at de, both pointers stepped
        next_s.io_we = 1'b1;
        next_s.io_addr = s.de;
        next_s.io_wdata = mem_rdata;
        next_s.hl = s.down ? s.hl - 16'h0001 : s.hl + 16'h0001;
        next_s.de = s.down ? s.de - 16'h0001 : s.de + 16'h0001;
        next_s.bc = s.bc - 16'h0001;
        if (s.rep && (s.bc != 16'h0001)) begin
          next_s.iter = 1'b1;
          next_s.st = MS_GAP;
        end else begin
          next_s.done = 1'b1;
          next_s.st = MS_IDLE;
        end
      end
      MS_GAP: begin
        if (!pause) begin
          next_s.mem_rd = 1'b1;
          next_s.st = MS_RD;
        end
      end
      MS_WHI: begin
        next_s.io_we = 1'b1;
        next_s.io_addr = s.io_addr + 16'h0001;
        next_s.io_wdata = s.word[15:8];
        next_s.done = 1'b1;
        next_s.st = MS_IDLE;
      end
      default: next_s.st = MS_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mem_rd = s.mem_rd;
  assign mem_addr = s.hl;
  assign io_we = s.io_we;
  assign io_addr = s.io_addr;
  assign io_wdata = s.io_wdata;
  assign hl = s.hl;
  assign de = s.de;
  assign bc = s.bc;
  assign busy = (s.st != MS_IDLE) && (s.st != MS_GAP);
  assign iter_pt = s.iter;
  assign done = s.done;

endmodule // cip_io_mover

// *** src/cip_unit.sv ***
`timescale 1ns/1ps
// Behaviour
// - io-prefixed single move: byte at hl written to io at de, both stepped
// - repeating moves open an interrupt point between iterations
// - word store to io writes two adjacent registers without interruption
// - accepted interrupt pushes return address then jumps to service routine
// - routine address: high byte from vector register, low byte fixed per source
// - separate vector-high registers for internal and external sources
// - vector registers moved only to or from the accumulator by special loads
// - restart traps only at 10,18,20,28,38; others refused
// - restart traps are never masked by priority
// - restart trap high byte comes from internal vector register
// - interrupt entry leaves code segment untouched; routines in root space
// - requests carry levels 1..3; processor runs at 0..3
// - higher request taken after current instruction, not after privileged one
// - current priority sits in the low two bits of priority stack
// - on acceptance priority stack shifts left two, low pair gets level
// - priority restore shifts priority stack right two
// - priority stack can be pushed to and popped from memory stack
// - priority set shifts left two and loads chosen level
// - masking: level must exceed processor priority; at 3 only traps
// - return from interrupt pops priority stack first, then return address
// - after a privileged instruction acceptance waits for a non-privileged one
module cip_unit import cip_pkg::*; (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   instr_done,
  input  wire logic                   instr_priv,
  input  wire logic                   op_valid,
  input  wire cip_op_type             op,
  input  wire logic [PRI_W-1:0]       op_level,
  input  wire logic [7:0]             rst_vec,
  input  wire logic [7:0]             acc_in,
  input  wire logic [15:0]            return_pc,
  input  wire logic [7:0]             stack_in,
  input  wire logic [NUM_INT-1:0]     int_req,
  input  wire logic [2*NUM_INT-1:0]   int_level,
  input  wire logic [NUM_EXT-1:0]     ext_req,
  input  wire logic [2*NUM_EXT-1:0]   ext_level,
  input  wire logic                   mv_start,
  input  wire cip_mv_cmd_type         mv_cmd,
  input  wire logic                   mv_down,
  input  wire logic [15:0]            hl_in,
  input  wire logic [15:0]            de_in,
  input  wire logic [15:0]            bc_in,
  input  wire logic [15:0]            word_in,
  input  wire logic [7:0]             mem_rdata,
  output logic                        busy,
  output logic [7:0]                  acc_out,
  output logic [7:0]                  priority_stack,
  output logic                        stack_we,
  output logic                        stack_rd,
  output logic [7:0]                  stack_wdata,
  output logic                        pc_load,
  output logic [15:0]                 pc_target,
  output logic [NUM_INT-1:0]          int_ack,
  output logic [NUM_EXT-1:0]          ext_ack,
  output logic                        illegal_op,
  output logic                        mem_rd,
  output logic [15:0]                 mem_addr,
  output logic                        io_we,
  output logic [15:0]                 io_addr,
  output logic [7:0]                  io_wdata,
  output logic [15:0]                 hl_out,
  output logic [15:0]                 de_out,
  output logic [15:0]                 bc_out,
  output logic                        mv_busy,
  output logic                        mv_done
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH_LO, ST_JUMP, ST_POP_WAIT, ST_POP_DATA
  } cip_st_type;

  typedef struct packed {
    cip_st_type          st;
    logic [7:0]          internal_vector_high;
    logic [7:0]          external_vector_high;
    logic [7:0]          priority_stack;
    logic [15:0]         ret;
    logic [15:0]         tgt;
    logic [7:0]          acc;
    logic [7:0]          stk_wd;
    logic                stk_we;
    logic                stk_rd;
    logic                pc_ld;
    logic [NUM_SRC-1:0]  ack;
    logic                illegal;
    logic                return_from_interrupt_instr;
    logic [1:0]          step;
  } cip_state_type;

  cip_state_type s;
  cip_state_type next_s;

  logic [NUM_SRC-1:0]   all_req;
  logic [2*NUM_SRC-1:0] all_lvl;
  logic                 arb_hit;
  logic [3:0]           arb_idx;
  logic [PRI_W-1:0]     arb_lvl;
  logic                 mv_gap;
  logic                 accept_pt;
  logic                 taking;

  function automatic logic rst_legal(input logic [7:0] v);
    rst_legal = (v == RST_V10) || (v == RST_V18) || (v == RST_V20) ||
                (v == RST_V28) || (v == RST_V38);
  endfunction

  function automatic logic [7:0] vec_low(input logic [3:0] idx);
    if (idx < 4'(NUM_INT)) begin
      vec_low = 8'(idx * INT_LOW_STEP);
    end else begin
      vec_low = EXT_LOW_BASE + 8'((idx - 4'(NUM_INT)) * EXT_LOW_STEP);
    end
  endfunction

  function automatic logic [7:0] push_pri(input logic [7:0] p, input logic [1:0] l);
    push_pri = {p[5:0], l};
  endfunction

  // levels come straight from each peripheral's own control bits
  assign all_req = {ext_req, int_req};
  assign all_lvl = {ext_level, int_level};

  cip_arbiter u_arb (
    .req     (all_req),
    .lvl     (all_lvl),
    .cur     (s.priority_stack[1:0]),
    .hit     (arb_hit),
    .idx     (arb_idx),
    .sel_lvl (arb_lvl)
  );

  cip_io_mover u_mover (
    .clock     (clock),
    .rst       (rst),
    .start     (mv_start),
    .cmd       (mv_cmd),
    .down      (mv_down),
    .hl_in     (hl_in),
    .de_in     (de_in),
    .bc_in     (bc_in),
    .word_in   (word_in),
    .mem_rdata (mem_rdata),
    .pause     (taking || (s.st != ST_IDLE)),
    .mem_rd    (mem_rd),
    .mem_addr  (mem_addr),
    .io_we     (io_we),
    .io_addr   (io_addr),
    .io_wdata  (io_wdata),
    .hl        (hl_out),
    .de        (de_out),
    .bc        (bc_out),
    .busy      (mv_busy),
    .iter_pt   (mv_gap),
    .done      (mv_done)
  );

  // privileged completion never opens a point; atomic moves block it
  assign accept_pt = (instr_done && !instr_priv && !mv_busy) || mv_gap;
  assign taking = (s.st == ST_IDLE) && !op_valid && accept_pt && arb_hit;

  always_comb begin
    next_s = s;
    next_s.stk_we = 1'b0;
    next_s.stk_rd = 1'b0;
    next_s.pc_ld = 1'b0;
    next_s.ack = '0;
    next_s.illegal = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (op_valid) begin
          case (op)
            OP_PRI_SET: next_s.priority_stack = push_pri(s.priority_stack, op_level);
            OP_PRI_RESTORE: next_s.priority_stack = {2'h0, s.priority_stack[7:2]};
            OP_PRI_PUSH: begin
              next_s.stk_we = 1'b1;
              next_s.stk_wd = s.priority_stack;
            end
            OP_PRI_POP: begin
              next_s.stk_rd = 1'b1;
              next_s.return_from_interrupt_instr = 1'b0;
              next_s.step = 2'h0;
              next_s.st = ST_POP_WAIT;
            end
            OP_INT_RETURN: begin
              next_s.stk_rd = 1'b1;
              next_s.return_from_interrupt_instr = 1'b1;
              next_s.step = 2'h0;
              next_s.st = ST_POP_WAIT;
            end
            OP_RD_INTV: next_s.acc = s.internal_vector_high;
            OP_WR_INTV: next_s.internal_vector_high = acc_in;
            OP_RD_EXTV: next_s.acc = s.external_vector_high;
            OP_WR_EXTV: next_s.external_vector_high = acc_in;
            OP_RST: begin
              if (rst_legal(rst_vec)) begin
                // traps ignore priority and leave the priority stack alone
                next_s.ret = return_pc;
                next_s.tgt = {s.internal_vector_high, rst_vec};
                next_s.stk_we = 1'b1;
                next_s.stk_wd = return_pc[15:8];
                next_s.st = ST_PUSH_LO;
              end else begin
                next_s.illegal = 1'b1;
              end
            end
            default: next_s.illegal = 1'b0;
          endcase
        end else if (taking) begin
          next_s.ret = return_pc;
          if (arb_idx < 4'(NUM_INT)) begin
            next_s.tgt = {s.internal_vector_high, vec_low(arb_idx)};
          end else begin
            next_s.tgt = {s.external_vector_high, vec_low(arb_idx)};
          end
          next_s.priority_stack = push_pri(s.priority_stack, arb_lvl);
          next_s.ack[arb_idx] = 1'b1;
          next_s.stk_we = 1'b1;
          next_s.stk_wd = return_pc[15:8];
          next_s.st = ST_PUSH_LO;
        end
      end
      ST_PUSH_LO: begin
        next_s.stk_we = 1'b1;
        next_s.stk_wd = s.ret[7:0];
        next_s.st = ST_JUMP;
      end
      ST_JUMP: begin
        next_s.pc_ld = 1'b1;
        next_s.st = ST_IDLE;
      end
      ST_POP_WAIT: next_s.st = ST_POP_DATA;
      ST_POP_DATA: begin
        case (s.step)
          2'h0: begin
            next_s.priority_stack = stack_in;
            if (s.return_from_interrupt_instr) begin
              next_s.stk_rd = 1'b1;
              next_s.step = 2'h1;
              next_s.st = ST_POP_WAIT;
            end else begin
              next_s.st = ST_IDLE;
            end
          end
          2'h1: begin
            next_s.ret[7:0] = stack_in;
            next_s.stk_rd = 1'b1;
            next_s.step = 2'h2;
            next_s.st = ST_POP_WAIT;
          end
          default: begin
            next_s.tgt = {stack_in, s.ret[7:0]};
            next_s.pc_ld = 1'b1;
            next_s.st = ST_IDLE;
          end
        endcase
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.internal_vector_high <= IVH_RESET;
      s.external_vector_high <= EVH_RESET;
      s.priority_stack <= PSTK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign busy = (s.st != ST_IDLE);
  assign acc_out = s.acc;
  assign priority_stack = s.priority_stack;
  assign stack_we = s.stk_we;
  assign stack_rd = s.stk_rd;
  assign stack_wdata = s.stk_wd;
  assign pc_load = s.pc_ld;
  // only a 16-bit root address is given; the code segment is never written
  assign pc_target = s.tgt;
  assign int_ack = s.ack[NUM_INT-1:0];
  assign ext_ack = s.ack[NUM_SRC-1:NUM_INT];
  assign illegal_op = s.illegal;

endmodule // cip_unit

// *** verif/cip_periph.sv ***
`timescale 1ns/1ps
module cip_periph #(parameter int N = 1) (
  input  wire logic [N-1:0]   fire,
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic [2*N-1:0] ctrl,
  input  wire logic [N-1:0]   ack,
  output logic      [N-1:0]   req,
  output logic      [2*N-1:0] level
);
  // request held until the core acknowledges it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) req <= '0;
    else req <= (req & ~ack) | fire;
  end
  // level comes from the device's own control bits
  assign level = ctrl;
endmodule // cip_periph

// *** verif/cip_unit_checker.sv ***
`timescale 1ns/1ps
module cip_unit_checker import cip_pkg::*; (
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             busy,
  input wire logic             op_valid,
  input wire cip_op_type       op,
  input wire logic [PRI_W-1:0] op_level,
  input wire logic [7:0]       rst_vec,
  input wire logic [7:0]       priority_stack,
  input wire logic             stack_we,
  input wire logic [7:0]       stack_wdata,
  input wire logic             pc_load,
  input wire logic [15:0]      pc_target,
  input wire logic [NUM_INT-1:0] int_ack,
  input wire logic [NUM_EXT-1:0] ext_ack,
  input wire logic             illegal_op,
  input wire logic             mv_start,
  input wire cip_mv_cmd_type   mv_cmd,
  input wire logic             mv_busy,
  input wire logic [15:0]      de_in,
  input wire logic             io_we,
  input wire logic [15:0]      io_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic take;
  logic acked;
  logic legal;
  assign take  = op_valid && !busy;
  assign acked = |int_ack || |ext_ack;
  assign legal = rst_vec inside {RST_V10, RST_V18, RST_V20, RST_V28, RST_V38};

  entry_seq_a: assert property (acked |-> stack_we ##1 stack_we ##1 pc_load)
    else $error("interrupt entry sequence wrong");
  ack_shift_a: assert property (acked |-> priority_stack[7:2] == $past(priority_stack[5:0]))
    else $error("priority stack not shifted on entry");
  ack_level_a: assert property (acked |-> priority_stack[1:0] > $past(priority_stack[1:0]))
    else $error("request taken without exceeding priority");
  trap_ok_a: assert property (take && op == OP_RST && legal |=>
    stack_we ##2 pc_load && pc_target[7:0] == $past(rst_vec, 3))
    else $error("restart trap not taken");
  trap_bad_a: assert property (take && op == OP_RST && !legal |=>
    illegal_op && !stack_we ##1 !stack_we && !pc_load)
    else $error("missing restart vector not refused");
  set_pri_a: assert property (take && op == OP_PRI_SET |=>
    priority_stack == {$past(priority_stack[5:0]), $past(op_level)})
    else $error("priority set wrong");
  restore_pri_a: assert property (take && op == OP_PRI_RESTORE |=>
    priority_stack == {2'h0, $past(priority_stack[7:2])})
    else $error("priority restore wrong");
  push_pri_a: assert property (take && op == OP_PRI_PUSH |=>
    stack_we && stack_wdata == $past(priority_stack))
    else $error("priority push wrong");
  word_io_a: assert property (mv_start && mv_cmd == MV_WORD && !mv_busy |=>
    io_we && io_addr == $past(de_in) ##1 io_we && io_addr == $past(de_in, 2) + 16'h0001)
    else $error("word store to io wrong");
  move_atomic_a: assert property (mv_busy |=> !acked)
    else $error("interrupt inside atomic move");

  cover property (acked && priority_stack[1:0] == 2'h3);
  cover property (take && op == OP_INT_RETURN);
  cover property (acked && !mv_busy ##1 mv_busy);
endmodule // cip_unit_checker

bind cip_unit cip_unit_checker u_cip_unit_checker (.*);

// *** verif/cip_unit_bench.sv ***
`timescale 1ns/1ps
module cip_unit_bench import cip_pkg::*;;
  // row fields: current priority, external, source index, level, expect taken
  typedef struct packed {logic [1:0] cur; logic ext; logic [2:0] idx; logic [1:0] lvl;
    logic take;} cip_row_type;
  cip_row_type rows [10] = '{9'h003, 9'h03f, 9'h04b, 9'h09a, 9'h0c5, 9'h124, 9'h12f,
    9'h1b6, 9'h1ce, 9'h010};
  logic [7:0] vecs [8] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38};
  logic clock = 0, rst = 1, instr_done = 0, instr_priv = 0, op_valid = 0;
  logic mv_start = 0, mv_down = 0, busy, stack_we, stack_rd, pc_load, illegal_op;
  logic mem_rd, io_we, mv_busy, mv_done, legal;
  cip_op_type op = OP_NONE;
  cip_mv_cmd_type mv_cmd = MV_SINGLE;
  logic [1:0]  op_level = 0;
  logic [7:0]  rst_vec = 0, acc_in = 0, stack_in = 0, mem_rdata = 0, lo;
  logic [7:0]  acc_out, priority_stack, stack_wdata, io_wdata;
  logic [15:0] return_pc = 0, hl_in = 0, de_in = 0, bc_in = 0, word_in = 0, ictl = 0;
  logic [15:0] pc_target, mem_addr, io_addr, hl_out, de_out, bc_out, int_level;
  logic [7:0]  int_req, int_ack, ifire = 0, got_i = 0;
  logic [1:0]  ext_req, ext_ack, efire = 0, got_e = 0;
  logic [3:0]  ectl = 0, ext_level;
  logic [9:0]  expv;
  logic        got_ill = 0, got_done = 0;
  int mismatches = 0, n_compared = 0, cyc = 0, n_io = 0, io_at_ack = 0;
  byte unsigned stk [$];
  cip_row_type r;

  cip_unit u_cip_unit (.*);
  cip_periph #(.N(NUM_INT)) u_int_dev (.clock(clock), .rst(rst), .fire(ifire),
    .ctrl(ictl), .ack(int_ack), .req(int_req), .level(int_level));
  cip_periph #(.N(NUM_EXT)) u_ext_dev (.clock(clock), .rst(rst), .fire(efire),
    .ctrl(ectl), .ack(ext_ack), .req(ext_req), .level(ext_level));

  initial begin
    forever #10 clock = ~clock;
  end

  // memory stack and memory read model
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      final_report;
    end
    got_i |= int_ack;
    got_e |= ext_ack;
    got_ill |= illegal_op;
    got_done |= mv_done;
    if (io_we) n_io++;
    if (|int_ack) io_at_ack = n_io;
    if (stack_we) stk.push_back(stack_wdata);
    if (stack_rd) stack_in <= #1 stk.pop_back();
    else stack_in <= #1 ~stack_in;
    mem_rdata <= #1 mem_rd ? mem_addr[7:0] ^ 8'h3c : ~mem_rdata;
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task settle;
    for (int k = 0; k < 12 && busy !== 1'b0; k++) tick(1);
    tick(3);
  endtask
  task do_reset;
    rst = 1;
    tick(2);
    rst = 0;
    {got_i, got_e, got_ill} = 0;
    stk.delete();
  endtask
  task do_op(input cip_op_type o, input logic [7:0] a);
    {op, op_level, rst_vec, acc_in, op_valid} = {o, a[1:0], a, a, 1'b1};
    tick(1);
    op_valid = 0;
    settle;
  endtask
  task done_pulse(input logic p);
    {instr_done, instr_priv} = {1'b1, p};
    tick(1);
    instr_done = 0;
    settle;
  endtask
  task raise(input logic [9:0] m);
    {efire, ifire} = m;
    tick(1);
    {efire, ifire} = 0;
    tick(1);
  endtask
  task mv_go(input cip_mv_cmd_type c);
    {mv_cmd, mv_start} = {c, 1'b1};
    tick(1);
    {mv_start, got_done, instr_done, instr_priv} = 4'b0010;
    tick(1);
    instr_done = 0;
    for (int k = 0; k < 40 && !got_done; k++) tick(1);
    chk("mv_done", 16'h0001, got_done);
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    foreach (rows[n]) begin
      r = rows[n];
      do_reset;
      do_op(OP_WR_INTV, 8'ha4);
      do_op(OP_WR_EXTV, 8'h5b);
      do_op(OP_PRI_SET, {6'h00, r.cur});
      {ictl, ectl, return_pc} = {{8{r.lvl}}, {2{r.lvl}}, 16'h4321};
      raise(r.ext ? 10'h100 << r.idx : 10'h001 << r.idx);
      done_pulse(0);
      expv = r.take ? 10'h001 << (r.ext ? r.idx + 8 : r.idx) : 10'h000;
      chk("ack", expv, {got_e, got_i});
      if (r.take) begin
        lo = r.ext ? EXT_LOW_BASE + EXT_LOW_STEP * r.idx : INT_LOW_STEP * r.idx;
        chk("target", {r.ext ? 8'h5b : 8'ha4, lo}, pc_target);
        chk("pri", {4'h0, r.cur, r.lvl}, priority_stack);
        chk("ret", 16'h4321, {stk[0], stk[1]});
      end
    end
    $display("test rows done");
    do_reset;
    chk("pri_rst", 16'h0000, priority_stack);
    do_op(OP_RD_EXTV, 8'h00);
    chk("evh_rst", 16'h0000, acc_out);
    do_op(OP_WR_INTV, 8'h77);
    do_op(OP_RD_INTV, 8'h00);
    chk("ivh_rd", 16'h0077, acc_out);
    ictl = 16'h0004;
    raise(10'h002);
    done_pulse(1);
    chk("priv", 16'h0000, {got_e, got_i});
    done_pulse(0);
    chk("unpriv", 16'h0002, {got_e, got_i});
    $display("test deferral done");
    do_reset;
    {ictl, ectl} = {16'h0810, 4'h2};
    raise(10'h124);
    done_pulse(0);
    chk("arb", 16'h0020, {got_e, got_i});
    $display("test arbitration done");
    do_reset;
    do_op(OP_WR_INTV, 8'h77);
    do_op(OP_PRI_SET, 8'h03);
    foreach (vecs[n]) begin
      got_ill = 0;
      do_op(OP_RST, vecs[n]);
      legal = vecs[n] inside {RST_V10, RST_V18, RST_V20, RST_V28, RST_V38};
      chk("illegal", !legal, got_ill);
      if (legal) chk("trap", {8'h77, vecs[n]}, pc_target);
    end
    chk("trap_pri", 16'h0003, priority_stack);
    $display("test traps done");
    do_reset;
    do_op(OP_PRI_SET, 8'h01);
    do_op(OP_PRI_SET, 8'h02);
    do_op(OP_PRI_PUSH, 8'h00);
    do_op(OP_PRI_RESTORE, 8'h00);
    chk("pri_res", 16'h0001, priority_stack);
    do_op(OP_PRI_POP, 8'h00);
    chk("pri_pop", 16'h0006, priority_stack);
    {ectl, return_pc} = {4'h3, 16'hbeef};
    raise(10'h100);
    done_pulse(0);
    chk("nest", 16'h001b, priority_stack);
    do_op(OP_PRI_PUSH, 8'h00);
    do_op(OP_PRI_SET, 8'h00);
    do_op(OP_INT_RETURN, 8'h00);
    chk("ret_pri", 16'h001b, priority_stack);
    chk("ret_pc", 16'hbeef, pc_target);
    $display("test stack done");
    do_reset;
    ictl = 16'h0100;
    raise(10'h010);
    {hl_in, de_in, bc_in, n_io} = {16'h1000, 16'h0040, 16'h0002, 32'd0};
    mv_go(MV_REPEAT);
    chk("gap_ack", 16'h0001, io_at_ack);
    chk("io_n", 16'h0002, n_io);
    chk("io_a", 16'h0041, io_addr);
    chk("io_d", 16'h003d, io_wdata);
    chk("hl", 16'h1002, hl_out);
    chk("de", 16'h0042, de_out);
    chk("bc", 16'h0000, bc_out);
    {word_in, de_in, n_io} = {16'ha55a, 16'h0080, 32'd0};
    mv_go(MV_WORD);
    chk("w_n", 16'h0002, n_io);
    chk("w_a", 16'h0081, io_addr);
    chk("w_d", 16'h00a5, io_wdata);
    do_reset;
    ictl = 16'h0040;
    raise(10'h008);
    {hl_in, de_in, mv_down} = {16'h2005, 16'h0090, 1'b1};
    mv_go(MV_SINGLE);
    chk("atomic", 16'h0000, {got_e, got_i});
    chk("dn_a", 16'h0090, io_addr);
    chk("dn_d", 16'h0039, io_wdata);
    chk("dn_p", 16'h048f, {hl_out[7:0], de_out[7:0]});
    done_pulse(0);
    chk("late_ack", 16'h0008, {got_e, got_i});
    $display("test mover done");
    final_report;
  end
endmodule // cip_unit_bench
